/* design/pdoc_pkg.sv */
// package: power data object layouts, codes and table sizes for the object codec
package pdoc_pkg;

    // object type codes in bits 31..30
    localparam logic [1:0] PDOC_TYPE_FIXED = 2'h0;
    localparam logic [1:0] PDOC_TYPE_BATT  = 2'h1;
    localparam logic [1:0] PDOC_TYPE_VAR   = 2'h2;

    // field positions
    localparam int PDOC_TYPE_LSB  = 30;
    localparam int PDOC_DRP_BIT   = 29;
    localparam int PDOC_B28_BIT   = 28;
    localparam int PDOC_EXT_BIT   = 27;
    localparam int PDOC_COMM_BIT  = 26;
    localparam int PDOC_DRS_BIT   = 25;
    localparam int PDOC_PEAK_LSB  = 20;
    localparam int PDOC_VHI_LSB   = 20;
    localparam int PDOC_VLO_LSB   = 10;
    localparam int PDOC_AMT_LSB   = 0;

    // units: voltage 50 mV, current 10 mA, battery power 250 mW
    localparam int PDOC_VOLT_UNIT_MV  = 50;
    localparam int PDOC_CURR_UNIT_MA  = 10;
    localparam int PDOC_POWER_UNIT_MW = 250;
    localparam logic [9:0] PDOC_SAFE5V_CODE = 10'(5000 / PDOC_VOLT_UNIT_MV);

    // peak current codes
    localparam logic [1:0] PDOC_PEAK_NONE = 2'h0;

    // object table: up to seven objects per data message
    localparam int PDOC_MAX_OBJ = 7;
    localparam int PDOC_IDX_W   = 3;

    // register map over the plain port
    localparam logic [7:0] PDOC_REG_CTRL   = 8'h00;
    localparam logic [7:0] PDOC_REG_STATUS = 8'h04;
    localparam logic [7:0] PDOC_REG_SRCTAB = 8'h20;
    localparam logic [7:0] PDOC_REG_SNKTAB = 8'h40;
    localparam logic [7:0] PDOC_REG_RXOBJ  = 8'h60;
    localparam logic [7:0] PDOC_REG_RXDEC  = 8'h64;
    localparam logic [31:0] PDOC_CTRL_RST  = 32'h0000_0000;

    // ctrl register bit positions
    localparam int PDOC_C_DRP   = 0;
    localparam int PDOC_C_SUSP  = 1;
    localparam int PDOC_C_MAINS = 2;
    localparam int PDOC_C_COMM  = 3;
    localparam int PDOC_C_DRS   = 4;
    localparam int PDOC_C_HUB   = 5;
    localparam int PDOC_C_UPALL = 6;
    localparam int PDOC_C_HIGH  = 7;
    localparam int PDOC_C_NSRC  = 8;
    localparam int PDOC_C_NSNK  = 12;

    // decoded view of one received object
    typedef struct packed {
        logic [1:0] kind;
        logic       ext_pwr;
        logic       comm;
        logic       drs;
        logic [1:0] peak;
        logic [9:0] v_hi;
        logic [9:0] v_lo;
        logic [9:0] amount;
    } pdoc_dec_t;

    // outgoing object stream word
    typedef struct packed {
        logic        valid;
        logic        last;
        logic [2:0]  count;
        logic [31:0] obj;
    } pdoc_tx_t;

    // stored table entry: kind, high voltage, low voltage, amount, peak code
    typedef struct packed {
        logic [1:0] kind;
        logic [1:0] peak;
        logic [9:0] v_hi;
        logic [9:0] v_lo;
        logic [9:0] amount;
    } pdoc_ent_t;

endpackage

/* design/pdoc_decode.sv */
// file: receive-side parser of one power data object
`timescale 1ns/1ps
module pdoc_decode
    import pdoc_pkg::*;
(
    input  wire logic [31:0] obj,    // received object
    output pdoc_dec_t        dec     // decoded fields
);

    // -------------------------------------------------------------
    // field split
    // -------------------------------------------------------------
    // reserved bits are not looked at, so a partner that sets them is accepted
    always_comb
    begin
        dec        = '0;
        dec.kind   = obj[PDOC_TYPE_LSB +: 2];
        dec.amount = obj[PDOC_AMT_LSB +: 10];
        dec.v_lo   = obj[PDOC_VLO_LSB +: 10];
        case (dec.kind)
            PDOC_TYPE_FIXED:
            begin
                dec.v_hi    = obj[PDOC_VLO_LSB +: 10];
                dec.ext_pwr = obj[PDOC_EXT_BIT];
                dec.comm    = obj[PDOC_COMM_BIT];
                dec.drs     = obj[PDOC_DRS_BIT];
                dec.peak    = obj[PDOC_PEAK_LSB +: 2];
            end
            default:
                dec.v_hi    = obj[PDOC_VHI_LSB +: 10];
        endcase
    end

endmodule

/* design/pdoc_codec.sv */
// file: power data object codec top, builds source and sink capability lists
//
// The address map and strobed register access were decided locally.
`timescale 1ns/1ps
module pdoc_codec
    import pdoc_pkg::*;
(
    input  wire logic        mclk,         // core clock, 50 MHz
    input  wire logic        rst_n,        // synchronous reset, active low
    input  wire logic [7:0]  reg_addr,     // register byte address
    input  wire logic [31:0] reg_wdata,    // register write data
    input  wire logic        reg_wr,       // write strobe
    input  wire logic        reg_rd,       // read strobe
    output logic      [31:0] reg_rdata,    // read data, cycle after strobe
    input  wire logic        get_src_cap,  // pulse: send source list
    input  wire logic        get_snk_cap,  // pulse: send sink list
    output pdoc_tx_t         tx,           // outgoing object stream
    input  wire logic [31:0] rx_obj,       // received object
    input  wire logic        rx_valid      // pulse: rx_obj is valid
);

    // -------------------------------------------------------------
    // state
    // -------------------------------------------------------------
    typedef enum logic [2:0] {
        PDOC_IDLE = 3'h1,
        PDOC_SRC  = 3'h2,
        PDOC_SNK  = 3'h4
    } pdoc_state_t;

    pdoc_state_t          state_reg,  state_next;
    logic [PDOC_IDX_W-1:0] idx_reg,   idx_next;
    logic [2:0]           cnt_reg,    cnt_next;
    logic [31:0]          ctrl_reg,   ctrl_next;
    pdoc_ent_t            src_reg [PDOC_MAX_OBJ];
    pdoc_ent_t            src_next[PDOC_MAX_OBJ];
    pdoc_ent_t            snk_reg [PDOC_MAX_OBJ];
    pdoc_ent_t            snk_next[PDOC_MAX_OBJ];
    logic [31:0]          rxobj_reg,  rxobj_next;
    logic [31:0]          rdata_reg,  rdata_next;
    pdoc_tx_t             tx_reg,     tx_next;
    pdoc_dec_t            rx_dec;

    // -------------------------------------------------------------
    // helpers
    // -------------------------------------------------------------
    // capability flag bits for the first object, qualified by policy
    function automatic logic [4:0] cap_flags(input logic [31:0] c, input logic sink);
        logic ext;
        ext = c[PDOC_C_MAINS] & (~c[PDOC_C_HUB] | c[PDOC_C_UPALL]);
        cap_flags = {c[PDOC_C_DRP],
                     sink ? c[PDOC_C_HIGH] : c[PDOC_C_SUSP],
                     ext,
                     c[PDOC_C_COMM],
                     c[PDOC_C_DRS]};
    endfunction

    // pack one table entry into a 32-bit object, reserved bits zero
    function automatic logic [31:0] pack_obj(input pdoc_ent_t e, input logic first,
                                             input logic sink, input logic [31:0] c);
        logic [31:0] o;
        o = '0;
        o[PDOC_TYPE_LSB +: 2] = e.kind;
        o[PDOC_AMT_LSB +: 10] = e.amount;
        o[PDOC_VLO_LSB +: 10] = e.v_lo;
        if (e.kind == PDOC_TYPE_FIXED)
        begin
            if (first)
                o[PDOC_DRS_BIT +: 5] = cap_flags(c, sink);
            // hubs and sinks never advertise overload; else code as stored
            if (!sink && !c[PDOC_C_HUB])
                o[PDOC_PEAK_LSB +: 2] = e.peak;
            else
                o[PDOC_PEAK_LSB +: 2] = PDOC_PEAK_NONE;
        end
        else
            o[PDOC_VHI_LSB +: 10] = e.v_hi;
        pack_obj = o;
    endfunction

    // same type and voltage as an earlier entry, later duplicate is merged
    function automatic logic dup_of(input pdoc_ent_t a, input pdoc_ent_t b);
        dup_of = (a.kind == b.kind) && (a.v_lo == b.v_lo)
                 && ((a.kind == PDOC_TYPE_FIXED) || (a.v_hi == b.v_hi));
    endfunction

    // sink entry as it goes out: index 0 forced to safe 5 V fixed
    function automatic pdoc_ent_t snk_ent(input pdoc_ent_t t [PDOC_MAX_OBJ], input int i);
        pdoc_ent_t e;
        e = t[i];
        if (i == 0)
        begin
            e.kind = PDOC_TYPE_FIXED;
            e.v_lo = PDOC_SAFE5V_CODE;
        end
        snk_ent = e;
    endfunction

    // a written word keeps the object layout; peak and high voltage share bits 21..20
    function automatic pdoc_ent_t word_ent(input logic [31:0] w);
        pdoc_ent_t e;
        e.kind   = w[PDOC_TYPE_LSB +: 2];
        e.peak   = w[PDOC_PEAK_LSB +: 2];
        e.v_hi   = w[PDOC_VHI_LSB +: 10];
        e.v_lo   = w[PDOC_VLO_LSB +: 10];
        e.amount = w[PDOC_AMT_LSB +: 10];
        word_ent = e;
    endfunction

    // table entry read back as the word that was written
    function automatic logic [31:0] ent_word(input pdoc_ent_t e);
        ent_word = {e.kind, e.v_hi, e.v_lo, e.amount};
    endfunction

    // first sink entry of its type and voltage; later ones are merged into it
    function automatic logic is_first(input pdoc_ent_t t [PDOC_MAX_OBJ], input int i);
        logic f;
        f = 1'b1;
        for (int k = 0; k < PDOC_MAX_OBJ; k++)
        begin
            if (k < i && dup_of(snk_ent(t, k), snk_ent(t, i)))
                f = 1'b0;
        end
        is_first = f;
    endfunction

    // number of distinct objects among the first n sink entries
    function automatic logic [2:0] uniq_cnt(input pdoc_ent_t t [PDOC_MAX_OBJ], input logic [2:0] n);
        logic [2:0] c;
        c = 3'h0;
        for (int k = 0; k < PDOC_MAX_OBJ; k++)
        begin
            if (k < int'(n) && is_first(t, k))
                c = c + 3'h1;
        end
        uniq_cnt = c;
    endfunction

    // next distinct sink entry after index i, or n when none is left
    function automatic logic [2:0] next_first(input pdoc_ent_t t [PDOC_MAX_OBJ], input logic [2:0] i,
                                              input logic [2:0] n);
        logic [2:0] r;
        r = n;
        for (int k = PDOC_MAX_OBJ - 1; k >= 0; k--)
        begin
            if (k > int'(i) && k < int'(n) && is_first(t, k))
                r = 3'(k);
        end
        next_first = r;
    endfunction

    // -------------------------------------------------------------
    // receive decode
    // -------------------------------------------------------------
    pdoc_decode u_dec
    (
        .obj (rxobj_reg),
        .dec (rx_dec)
    );

    // -------------------------------------------------------------
    // registers and list sequencer, next values
    // -------------------------------------------------------------
    always_comb
    begin
        logic [2:0]  nsrc;
        logic [2:0]  nsnk;
        pdoc_ent_t   e;
        pdoc_ent_t   m;
        int          i;
        int          j;
        logic [2:0]  nxt;
        i          = 0;
        j          = 0;
        nxt        = 3'h0;
        nsrc       = ctrl_reg[PDOC_C_NSRC +: 3];
        nsnk       = ctrl_reg[PDOC_C_NSNK +: 3];
        e          = '0;
        m          = '0;
        state_next = state_reg;
        idx_next   = idx_reg;
        cnt_next   = cnt_reg;
        ctrl_next  = ctrl_reg;
        src_next   = src_reg;
        snk_next   = snk_reg;
        rxobj_next = rx_valid ? rx_obj : rxobj_reg;
        rdata_next = '0;
        tx_next    = '0;

        // register writes; table entries use the object word layout
        if (reg_wr)
        begin
            if (reg_addr == PDOC_REG_CTRL)
                ctrl_next = reg_wdata;
            for (i = 0; i < PDOC_MAX_OBJ; i++)
            begin
                if (reg_addr == PDOC_REG_SRCTAB + 8'(4 * i))
                    src_next[i] = word_ent(reg_wdata);
                if (reg_addr == PDOC_REG_SNKTAB + 8'(4 * i))
                    snk_next[i] = word_ent(reg_wdata);
            end
        end

        // register reads, unmapped reads zero
        if (reg_rd)
        begin
            if (reg_addr == PDOC_REG_CTRL)
                rdata_next = ctrl_reg;
            else if (reg_addr == PDOC_REG_STATUS)
                rdata_next = {26'h0, cnt_reg, state_reg};
            else if (reg_addr == PDOC_REG_RXOBJ)
                rdata_next = rxobj_reg;
            else if (reg_addr == PDOC_REG_RXDEC)
                rdata_next = {rx_dec.kind, rx_dec.ext_pwr, rx_dec.comm, rx_dec.drs, rx_dec.peak,
                              5'h0, rx_dec.v_hi, rx_dec.amount};  // low voltage is in the raw word
            for (i = 0; i < PDOC_MAX_OBJ; i++)
            begin
                if (reg_addr == PDOC_REG_SRCTAB + 8'(4 * i))
                    rdata_next = ent_word(src_reg[i]);
                if (reg_addr == PDOC_REG_SNKTAB + 8'(4 * i))
                    rdata_next = ent_word(snk_reg[i]);
            end
        end

        case (state_reg)
            PDOC_IDLE:
            begin
                // sink request wins; a zero source count sends nothing
                if (get_snk_cap)
                begin
                    state_next = PDOC_SNK;
                    idx_next   = '0;
                    cnt_next   = (nsnk == 3'h0) ? 3'h1 : nsnk;
                end
                else if (get_src_cap && nsrc != 3'h0)
                begin
                    state_next = PDOC_SRC;
                    idx_next   = '0;
                    cnt_next   = nsrc;
                end
            end
            PDOC_SRC:
            begin
                tx_next.valid = 1'b1;
                tx_next.count = cnt_reg;
                tx_next.last  = (3'(idx_reg) == cnt_reg - 3'h1);
                tx_next.obj   = pack_obj(src_reg[idx_reg], idx_reg == '0, 1'b0, ctrl_reg);
                idx_next      = idx_reg + 3'h1;
                if (tx_next.last)
                    state_next = PDOC_IDLE;
            end
            PDOC_SNK:
            begin
                // only the first entry of a type and voltage goes out, at the highest
                // amount of its group; duplicates are skipped so the count stays exact
                m = snk_ent(snk_reg, int'(idx_reg));
                for (j = 0; j < PDOC_MAX_OBJ; j++)
                begin
                    e = snk_ent(snk_reg, j);
                    if (j > int'(idx_reg) && j < int'(cnt_reg) && dup_of(e, m) && e.amount > m.amount)
                        m.amount = e.amount;
                end
                nxt           = next_first(snk_reg, idx_reg, cnt_reg);
                tx_next.valid = 1'b1;
                tx_next.count = uniq_cnt(snk_reg, cnt_reg);
                tx_next.last  = (nxt == cnt_reg);
                tx_next.obj   = pack_obj(m, idx_reg == '0, 1'b1, ctrl_reg);
                idx_next      = nxt;
                if (tx_next.last)
                    state_next = PDOC_IDLE;
            end
            default:
                state_next = PDOC_IDLE;
        endcase
    end

    // -------------------------------------------------------------
    // flip-flops
    // -------------------------------------------------------------
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            state_reg <= PDOC_IDLE;
            idx_reg   <= '0;
            cnt_reg   <= '0;
            ctrl_reg  <= PDOC_CTRL_RST;
            src_reg   <= '{default: '0};
            snk_reg   <= '{default: '0};
            rxobj_reg <= '0;
            rdata_reg <= '0;
            tx_reg    <= '0;
        end
        else
        begin
            state_reg <= state_next;
            idx_reg   <= idx_next;
            cnt_reg   <= cnt_next;
            ctrl_reg  <= ctrl_next;
            src_reg   <= src_next;
            snk_reg   <= snk_next;
            rxobj_reg <= rxobj_next;
            rdata_reg <= rdata_next;
            tx_reg    <= tx_next;
        end
    end

    assign reg_rdata = rdata_reg;  // registered read data
    assign tx        = tx_reg;     // registered object stream

endmodule

/* sim/pdoc_codec_asserts.sv */
// checker: port-level assertions for the power object codec
`timescale 1ns/1ps
module pdoc_codec_asserts
    import pdoc_pkg::*;
(
    input  wire logic        mclk,        // core clock
    input  wire logic        rst_n,       // sync reset, active low
    input  wire logic [7:0]  reg_addr,    // register address
    input  wire logic [31:0] reg_wdata,   // write data
    input  wire logic        reg_wr,      // write strobe
    input  wire logic        reg_rd,      // read strobe
    input  wire logic [31:0] reg_rdata,   // read data
    input  wire logic        get_src_cap, // source list request
    input  wire logic        get_snk_cap, // sink list request
    input  wire pdoc_tx_t    tx,          // object stream
    input  wire logic [31:0] rx_obj,      // received object
    input  wire logic        rx_valid     // received strobe
);
    //--------------------------------------------------
    // helper state
    //--------------------------------------------------
    logic [31:0] ctrl_reg, ctrl_next; // shadow of the control word
    logic [2:0]  widx_reg, widx_next; // words seen in the current list
    logic        busy_reg, busy_next; // a request may still be in flight
    logic        fix;                 // a fixed object is on the stream

    assign fix = tx.valid && tx.obj[31:30] == PDOC_TYPE_FIXED;

    // busy is set by any request outside the cycle of a last word, so an ignored one only weakens the answer check
    always_comb
    begin
        ctrl_next = (reg_wr && reg_addr == PDOC_REG_CTRL) ? reg_wdata : ctrl_reg;
        widx_next = !tx.valid ? widx_reg : (tx.last ? 3'h0 : widx_reg + 3'h1);
        busy_next = (busy_reg || get_snk_cap || get_src_cap) && !(tx.valid && tx.last);
    end

    // register the helpers
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            ctrl_reg <= PDOC_CTRL_RST;
            widx_reg <= 3'h0;
            busy_reg <= 1'b0;
        end
        else
        begin
            ctrl_reg <= ctrl_next;
            widx_reg <= widx_next;
            busy_reg <= busy_next;
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    a_rdata_quiet: assert property (reg_rdata != 32'h0 |-> $past(reg_rd)) else $error("read data outside read slot");
    a_snk_answer: assert property (get_snk_cap && !busy_reg && !tx.valid |-> ##[1:3] (fix && tx.obj[19:10] == PDOC_SAFE5V_CODE))
        else $error("sink list did not start with the safe level");
    a_count_const: assert property (tx.valid && !tx.last |=> tx.valid && $stable(tx.count))
        else $error("list broken or count changed");
    a_last_count: assert property (tx.valid && tx.last |-> tx.count == 3'(widx_reg + 3'h1))
        else $error("count differs from words sent");
    a_count_nonzero: assert property (tx.valid |-> tx.count != 3'h0) else $error("empty list");
    a_type_legal: assert property (tx.valid |-> tx.obj[31:30] != 2'h3) else $error("undefined object type");
    a_resv_zero: assert property (fix |-> tx.obj[24:22] == 3'h0) else $error("reserved bits set");
    a_hub_no_peak: assert property (fix && ctrl_reg[PDOC_C_HUB] |-> tx.obj[21:20] == 2'h0)
        else $error("hub offered overload");
    a_ext_flag: assert property (fix && tx.obj[27] |-> ctrl_reg[PDOC_C_MAINS] && (!ctrl_reg[PDOC_C_HUB] || ctrl_reg[PDOC_C_UPALL]))
        else $error("external power flag without mains");
    a_comm_flag: assert property (fix && tx.obj[26] |-> ctrl_reg[PDOC_C_COMM]) else $error("comm flag set");
    a_drs_flag: assert property (fix && tx.obj[25] |-> ctrl_reg[PDOC_C_DRS]) else $error("swap flag set");

    c_three_words: cover property (tx.valid && tx.last && tx.count == 3'h3);
    c_peak_top: cover property (fix && tx.obj[21:20] == 2'h3);
    c_read_data: cover property (reg_rd ##1 reg_rdata != 32'h0);
endmodule

bind pdoc_codec pdoc_codec_asserts i_pdoc_codec_asserts (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .get_src_cap(get_src_cap),
    .get_snk_cap(get_snk_cap), .tx(tx), .rx_obj(rx_obj), .rx_valid(rx_valid));

/* sim/pdoc_peer.sv */
// partner model: protocol logic at the far end that takes object lists and sends objects
`timescale 1ns/1ps
module pdoc_peer
    import pdoc_pkg::*;
(
    input  wire logic     mclk,    // core clock
    input  wire logic     rst_n,   // reset, active low
    input  wire pdoc_tx_t tx,      // object stream from the codec
    output logic [31:0]   rx_obj,  // object towards the codec
    output logic          rx_valid // strobe for rx_obj
);
    //--------------------------------------------------
    // list capture and object sending
    //--------------------------------------------------
    logic [31:0] got [0:7];
    int          n = 0;
    int          lists = 0;
    int          bad = 0;
    logic        open = 1'b0;

    initial rx_obj = 32'h0;
    initial rx_valid = 1'b0;

    // collect each list; the count on the last word must equal the words collected
    always @(posedge mclk)
    begin
        if (rst_n && tx.valid)
        begin
            got[open ? n : 0] <= tx.obj;
            n <= open ? n + 1 : 1;
            open <= !tx.last;
            if (tx.last)
                lists <= lists + 1;
            if (tx.last && int'(tx.count) != (open ? n + 1 : 1))
                bad <= bad + 1;
        end
    end

    // one object per strobe; afterwards the bus shows the inverse, never a stale copy
    task automatic send(input logic [31:0] o);
        @(posedge mclk);
        rx_obj <= o;
        rx_valid <= 1'b1;
        @(posedge mclk);
        rx_valid <= 1'b0;
        rx_obj <= ~o;
    endtask
endmodule

/* sim/tb_top.sv */
// testbench: register-driven source and sink list checks for the object codec
`timescale 1ns/1ps
module tb_top;
    import pdoc_pkg::*;
    //--------------------------------------------------
    // signals, design and partner
    //--------------------------------------------------
    logic        mclk;
    logic        rst_n;
    logic [7:0]  reg_addr;
    logic [31:0] reg_wdata;
    logic        reg_wr;
    logic        reg_rd;
    logic [31:0] reg_rdata;
    logic        get_src_cap;
    logic        get_snk_cap;
    pdoc_tx_t    tx;
    logic [31:0] rx_obj;
    logic        rx_valid;
    int          err_count;
    int          samples_checked;
    int          l0;
    logic [31:0] v;
    logic [2:0]  b;
    logic [1:0]  pk;
    logic        ext;

    pdoc_codec i_pdoc_codec (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .get_src_cap(get_src_cap),
        .get_snk_cap(get_snk_cap), .tx(tx), .rx_obj(rx_obj), .rx_valid(rx_valid));
    pdoc_peer i_pdoc_peer (.mclk(mclk), .rst_n(rst_n), .tx(tx), .rx_obj(rx_obj), .rx_valid(rx_valid));

    // 50 MHz core clock
    initial
    begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        samples_checked++;
        if (got !== exp)
        begin
            err_count++;
            $display("ERROR t=%0t %s: got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask

    task automatic req(input logic snk);
        @(posedge mclk);
        get_snk_cap <= snk;
        get_src_cap <= !snk;
        @(posedge mclk);
        get_snk_cap <= 1'b0;
        get_src_cap <= 1'b0;
    endtask

    // request a list and wait, bounded, until the partner has seen its last word
    task automatic run_list(input logic snk);
        l0 = i_pdoc_peer.lists;
        req(snk);
        for (int k = 0; k < 40 && i_pdoc_peer.lists == l0; k++)
            @(negedge mclk);
        if (i_pdoc_peer.lists == l0)
        begin
            err_count++;
            $display("ERROR t=%0t list never ended", $time);
            final_report();
        end
    endtask

    task automatic final_report;
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    //--------------------------------------------------
    // main sequence
    //--------------------------------------------------
    initial
    begin
        err_count = 0;
        samples_checked = 0;
        rst_n = 1'b0;
        reg_addr = 8'h0;
        reg_wdata = 32'h0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        get_src_cap = 1'b0;
        get_snk_cap = 1'b0;
        repeat (10) @(posedge mclk);
        rst_n <= 1'b1;
        rd(PDOC_REG_CTRL, v);
        chk(v, PDOC_CTRL_RST, "ctrl reset");
        rd(PDOC_REG_STATUS, v);
        chk({29'h0, v[2:0]}, 32'h1, "idle after reset");
        wr(8'h10, 32'hffff_ffff);
        rd(8'h10, v);
        chk(v, 32'h0, "unmapped read");
        $display("test reset done");
        // source lists: eight flag, hub and peak combinations from three bits; a hub must hide overload
        for (int i = 0; i < 8; i++)
        begin
            b = 3'(i);
            ext = b[0] && (!b[1] || b[2]);
            pk = b[1] ? 2'h0 : {b[2], b[0]};
            wr(PDOC_REG_CTRL, {24'h3, 1'b0, b[2], b[1], ~b[2], b[2], b[0], ~b[0], b[0]});
            wr(PDOC_REG_SRCTAB, {10'h0, b[2], b[0], 10'h064, 10'h01e});
            wr(8'(PDOC_REG_SRCTAB + 8'h4), {12'h0, 10'h0b4, 10'h0c8});
            wr(8'(PDOC_REG_SRCTAB + 8'h8), {2'h1, 10'h0a0, 10'h064, 10'h028});
            run_list(1'b0);
            chk(32'(i_pdoc_peer.n), 32'h3, "source words");
            chk(i_pdoc_peer.got[0], {2'h0, b[0], ~b[0], ext, b[2], ~b[2], 3'h0, pk, 10'h064, 10'h01e}, "src0");
            chk(i_pdoc_peer.got[1], {12'h0, 10'h0b4, 10'h0c8}, "src1");
            chk(i_pdoc_peer.got[2], {2'h1, 10'h0a0, 10'h064, 10'h028}, "src2");
        end
        $display("test source lists done");
        // sink lists with a duplicated 12 V level, with and without higher capability
        for (int j = 0; j < 2; j++)
        begin
            wr(PDOC_REG_CTRL, 32'h420f | (32'(j) << 7));
            wr(PDOC_REG_SNKTAB, {2'h3, 10'h0, 10'h064, 10'h050});
            wr(8'(PDOC_REG_SNKTAB + 8'h4), {12'h0, 10'h0f0, 10'h064});
            wr(8'(PDOC_REG_SNKTAB + 8'h8), {12'h0, 10'h0f0, 10'h0c8});
            wr(8'(PDOC_REG_SNKTAB + 8'hc), {2'h2, 10'h12c, 10'h0b4, 10'h096});
            run_list(1'b1);
            chk(32'(i_pdoc_peer.n), 32'h3, "sink words");
            chk(i_pdoc_peer.got[0], {3'h1, 1'(j), 3'h6, 5'h0, 10'h064, 10'h050}, "snk0");
            chk(i_pdoc_peer.got[1], {12'h0, 10'h0f0, 10'h0c8}, "snk1");
            chk(i_pdoc_peer.got[2], {2'h2, 10'h12c, 10'h0b4, 10'h096}, "snk2");
        end
        $display("test sink lists done");
        // empty sink table still yields the safe level; a request while busy is dropped
        wr(PDOC_REG_CTRL, 32'h0000_4000);
        l0 = i_pdoc_peer.lists;
        req(1'b1);
        req(1'b1);
        repeat (12) @(negedge mclk);
        chk(32'(i_pdoc_peer.lists - l0), 32'h1, "busy request dropped");
        wr(PDOC_REG_CTRL, 32'h0000_0000);
        run_list(1'b1);
        chk(32'(i_pdoc_peer.n), 32'h1, "minimum sink list");
        chk({20'h0, i_pdoc_peer.got[0][31:30], i_pdoc_peer.got[0][19:10]}, {22'h0, PDOC_SAFE5V_CODE}, "safe");
        // a source request with an empty table is refused
        l0 = i_pdoc_peer.lists;
        req(1'b0);
        repeat (10) @(negedge mclk);
        chk(32'(i_pdoc_peer.lists - l0), 32'h0, "empty source refused");
        chk(32'(i_pdoc_peer.bad), 32'h0, "partner count check");
        $display("test refusals done");
        // received object with reserved bits set is taken, not rejected
        i_pdoc_peer.send(32'h01c1_9123);
        rd(PDOC_REG_RXOBJ, v);
        chk(v, 32'h01c1_9123, "rx capture");
        rd(PDOC_REG_RXDEC, v);
        chk({22'h0, v[9:0]}, 32'h123, "rx amount");
        $display("test receive done");
        final_report();
    end
endmodule
